//--- rtl/spi_buffer_status_flags.v
// transmit and receive buffer status flags of the serial unit
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "spi_buffer_consts.vh"

module spi_buffer_status_flags #(
    parameter DATA_W = 32,
    parameter DEPTH  = 8,
    parameter PTR_W  = 3
) (
    input  wire              i_core_clk,  // core clock, 10 MHz
    input  wire              i_reset_n,   // async reset, active low
    input  wire [7:0]        i_addr,      // register byte address
    input  wire [31:0]       i_wr_data,   // register write data
    input  wire              i_wr_en,     // write strobe
    input  wire              i_rd_en,     // read strobe
    output reg  [31:0]       o_rd_data,   // read data, cycle after strobe
    output wire              o_tx_valid,  // word for shift register
    input  wire              i_tx_ready,  // shift register takes word
    output wire [DATA_W-1:0] o_tx_data,   // word to shift out
    input  wire              i_rx_valid,  // received word offered
    output wire              o_rx_ready,  // room for received word
    input  wire [DATA_W-1:0] i_rx_data    // received word
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg  [DATA_W-1:0] tx_mem [0:DEPTH-1];
    reg  [DATA_W-1:0] rx_mem [0:DEPTH-1];

    reg               deep_fifo_select_reg;
    reg               tx_empty_std_reg;
    reg               tx_full_std_reg;
    reg               rx_full_std_reg;
    reg  [31:0]       rd_data_next;
    reg  [31:0]       status_word;

    // ----------------------------------------
    // pointer nets
    // ----------------------------------------
    wire [PTR_W-1:0]  core_write_pointer;
    wire [PTR_W-1:0]  core_write_pointer_inc;
    wire [PTR_W-1:0]  shifter_read_pointer;
    wire [PTR_W-1:0]  shifter_write_pointer;
    wire [PTR_W-1:0]  shifter_write_pointer_inc;
    wire [PTR_W-1:0]  core_read_pointer;

    // ----------------------------------------
    // decode nets
    // ----------------------------------------
    wire              hit_data;
    wire              hit_control;
    wire              data_write;
    wire              data_read;
    wire              control_write;
    wire              mode_change;

    // ----------------------------------------
    // flag nets
    // ----------------------------------------
    wire              tx_buffer_empty_flag;
    wire              tx_buffer_full_flag;
    wire              rx_buffer_full_flag;
    wire              rx_fifo_empty_flag;
    wire              tx_full_enh;
    wire              rx_full_enh;
    wire              tx_has_word;

    // ----------------------------------------
    // path nets
    // ----------------------------------------
    wire              tx_push;
    wire              tx_move;
    wire              tx_stage_ready;
    wire              rx_stage_valid;
    wire [DATA_W-1:0] rx_stage_data;
    wire              rx_move;
    wire              rx_pop;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    assign hit_data      = (i_addr == `OFS_DATA_WINDOW);
    assign hit_control   = (i_addr == `OFS_BUF_CONTROL);
    assign data_write    = i_wr_en & hit_data;
    assign data_read     = i_rd_en & hit_data;
    assign control_write = i_wr_en & hit_control;
    // switching modes mid-stream would leave pointers meaningless
    assign mode_change   = control_write & (i_wr_data[`BIT_DEEP_FIFO] != deep_fifo_select_reg);

    // ----------------------------------------
    // mode control
    // ----------------------------------------
    // a same-value write leaves pointers and flags alone
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            deep_fifo_select_reg <= `RST_DEEP_FIFO;
        end else if (control_write) begin
            deep_fifo_select_reg <= i_wr_data[`BIT_DEEP_FIFO];
        end
    end

    // ----------------------------------------
    // fifo pointers
    // ----------------------------------------
    ptr_wrap_counter #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W)
    ) u_core_wr_ptr (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (mode_change),
        .i_advance  (tx_push),
        .o_ptr      (core_write_pointer),
        .o_ptr_inc  (core_write_pointer_inc)
    );

    ptr_wrap_counter #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W)
    ) u_shifter_rd_ptr (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (mode_change),
        .i_advance  (tx_move),
        .o_ptr      (shifter_read_pointer),
        .o_ptr_inc  ()
    );

    ptr_wrap_counter #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W)
    ) u_shifter_wr_ptr (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (mode_change),
        .i_advance  (rx_move),
        .o_ptr      (shifter_write_pointer),
        .o_ptr_inc  (shifter_write_pointer_inc)
    );

    ptr_wrap_counter #(
        .DEPTH (DEPTH),
        .PTR_W (PTR_W)
    ) u_core_rd_ptr (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_clear    (mode_change),
        .i_advance  (rx_pop),
        .o_ptr      (core_read_pointer),
        .o_ptr_inc  ()
    );

    // ----------------------------------------
    // pointer comparisons, full flags for enhanced mode only
    // ----------------------------------------
    // tx full by pointers
    assign tx_full_enh = (core_write_pointer_inc == shifter_read_pointer);
    assign rx_full_enh = (shifter_write_pointer_inc == core_read_pointer);
    assign rx_fifo_empty_flag = (core_read_pointer == shifter_write_pointer);
    assign tx_has_word = (core_write_pointer != shifter_read_pointer);

    // ----------------------------------------
    // transmit path
    // ----------------------------------------
    // a write into a full buffer is dropped, the held word is kept
    assign tx_push = data_write & ~tx_buffer_full_flag & ~mode_change;
    assign tx_move = tx_has_word & tx_stage_ready & ~mode_change;

    // ----------------------------------------
    // transmit storage
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        if (tx_push) begin
            tx_mem[core_write_pointer] <= i_wr_data[DATA_W-1:0];
        end
    end

    // ----------------------------------------
    // transmit staging
    // ----------------------------------------
    // two words wait here while the shifter stalls
    pair_buffer #(
        .DATA_W (DATA_W)
    ) u_tx_stage (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (tx_move),
        .o_in_ready  (tx_stage_ready),
        .i_in_data   (tx_mem[shifter_read_pointer]),
        .o_out_valid (o_tx_valid),
        .i_out_ready (i_tx_ready),
        .o_out_data  (o_tx_data)
    );

    // ----------------------------------------
    // standard mode transmit flags
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_empty_std_reg <= `RST_TX_EMPTY;
            tx_full_std_reg  <= `RST_TX_FULL;
        end else if (mode_change) begin
            tx_empty_std_reg <= `RST_TX_EMPTY;
            tx_full_std_reg  <= `RST_TX_FULL;
        end else if (!deep_fifo_select_reg) begin
            if (tx_push) begin
                tx_empty_std_reg <= 1'b0;
                tx_full_std_reg  <= 1'b1;
            end else if (tx_move) begin
                tx_empty_std_reg <= 1'b1;
                tx_full_std_reg  <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // transmit flag selection
    // ----------------------------------------
    // empty in both modes
    assign tx_buffer_empty_flag = deep_fifo_select_reg ? ~tx_has_word : tx_empty_std_reg;
    assign tx_buffer_full_flag  = deep_fifo_select_reg ? tx_full_enh : tx_full_std_reg;

    // ----------------------------------------
    // receive path
    // ----------------------------------------
    // a full buffer stalls the shifter instead of losing a word
    pair_buffer #(
        .DATA_W (DATA_W)
    ) u_rx_stage (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_rx_valid),
        .o_in_ready  (o_rx_ready),
        .i_in_data   (i_rx_data),
        .o_out_valid (rx_stage_valid),
        .i_out_ready (rx_move),
        .o_out_data  (rx_stage_data)
    );

    assign rx_move = rx_stage_valid & ~rx_buffer_full_flag & ~mode_change;
    assign rx_pop  = data_read & ~rx_fifo_empty_flag & ~mode_change;

    // ----------------------------------------
    // receive storage
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        if (rx_move) begin
            rx_mem[shifter_write_pointer] <= rx_stage_data;
        end
    end

    // ----------------------------------------
    // standard mode receive flag
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_full_std_reg <= `RST_RX_FULL;
        end else if (mode_change) begin
            rx_full_std_reg <= `RST_RX_FULL;
        end else if (!deep_fifo_select_reg) begin
            if (rx_move) begin
                rx_full_std_reg <= 1'b1;
            end else if (rx_pop) begin
                rx_full_std_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // receive flag selection
    // ----------------------------------------
    // enhanced flags need no register, the pointers are the state
    assign rx_buffer_full_flag = deep_fifo_select_reg ? rx_full_enh : rx_full_std_reg;

    // ----------------------------------------
    // status word
    // ----------------------------------------
    always @* begin
        status_word                   = 32'h00000000;
        status_word[`BIT_RX_FULL]     = rx_buffer_full_flag;
        status_word[`BIT_TX_FULL]     = tx_buffer_full_flag;
        status_word[`BIT_STAT_UNUSED] = 1'b0;
        status_word[`BIT_TX_EMPTY]    = tx_buffer_empty_flag;
        status_word[`BIT_RX_EMPTY]    = rx_fifo_empty_flag;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @* begin
        rd_data_next = 32'h00000000;
        if (i_rd_en) begin
            case (i_addr)
                `OFS_DATA_WINDOW: begin
                    rd_data_next = {{(32-DATA_W){1'b0}}, rx_mem[core_read_pointer]};
                end
                `OFS_BUF_STATUS: begin
                    rd_data_next = status_word;
                end
                `OFS_BUF_CONTROL: begin
                    rd_data_next = {31'h00000000, deep_fifo_select_reg};
                end
                default: begin
                    rd_data_next = 32'h00000000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    // read data stands one cycle only
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 32'h00000000;
        end else begin
            o_rd_data <= rd_data_next;
        end
    end

endmodule // spi_buffer_status_flags

`default_nettype wire

//--- rtl/spi_buffer_consts.vh
// constants for the serial buffer status block
`ifndef SPI_BUFFER_CONSTS_VH
`define SPI_BUFFER_CONSTS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_DATA_WINDOW   8'h00
`define OFS_BUF_STATUS    8'h04
`define OFS_BUF_CONTROL   8'h08

// ----------------------------------------
// status field positions
// ----------------------------------------
`define BIT_RX_FULL       0
`define BIT_TX_FULL       1
`define BIT_STAT_UNUSED   2
`define BIT_TX_EMPTY      3
`define BIT_RX_EMPTY      5

// ----------------------------------------
// control field positions
// ----------------------------------------
`define BIT_DEEP_FIFO     0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_TX_EMPTY      1'h1
`define RST_TX_FULL       1'h0
`define RST_RX_FULL       1'h0
`define RST_DEEP_FIFO     1'h0

`endif

//--- rtl/ptr_wrap_counter.v
// fifo pointer that wraps modulo the fifo depth
`timescale 1ns/10ps
`default_nettype none

module ptr_wrap_counter #(
    parameter DEPTH = 8,
    parameter PTR_W = 3
) (
    input  wire             i_core_clk,  // core clock
    input  wire             i_reset_n,   // async reset, active low
    input  wire             i_clear,     // return pointer to zero
    input  wire             i_advance,   // step pointer by one
    output wire [PTR_W-1:0] o_ptr,       // current pointer
    output wire [PTR_W-1:0] o_ptr_inc    // pointer plus one, wrapped
);

    localparam integer     LAST_INT = DEPTH - 1;
    localparam [PTR_W-1:0] LAST     = LAST_INT[PTR_W-1:0];

    reg  [PTR_W-1:0] ptr_reg;

    // ----------------------------------------
    // pointer register
    // ----------------------------------------
    // wrap at depth
    assign o_ptr_inc = (ptr_reg == LAST) ? {PTR_W{1'b0}} : ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
    assign o_ptr     = ptr_reg;

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_reg <= {PTR_W{1'b0}};
        end else if (i_clear) begin
            ptr_reg <= {PTR_W{1'b0}};
        end else if (i_advance) begin
            ptr_reg <= o_ptr_inc;
        end
    end

endmodule // ptr_wrap_counter

`default_nettype wire

//--- rtl/pair_buffer.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
    parameter DATA_W = 32
) (
    input  wire              i_core_clk,  // core clock
    input  wire              i_reset_n,   // async reset, active low
    input  wire              i_in_valid,  // word offered
    output wire              o_in_ready,  // room for a word
    input  wire [DATA_W-1:0] i_in_data,   // offered word
    output wire              o_out_valid, // word available
    input  wire              i_out_ready, // drain takes word
    output wire [DATA_W-1:0] o_out_data   // head word, registered
);

    reg  [DATA_W-1:0] head_reg;
    reg  [DATA_W-1:0] tail_reg;
    reg  [1:0]        count_reg;
    wire              push;
    wire              pop;

    assign o_in_ready  = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data  = head_reg;
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            head_reg  <= {DATA_W{1'b0}};
            tail_reg  <= {DATA_W{1'b0}};
            count_reg <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count_reg == 2'h0) begin
                        head_reg <= i_in_data;
                    end else begin
                        tail_reg <= i_in_data;
                    end
                    count_reg <= count_reg + 2'h1;
                end
                2'b01: begin
                    head_reg  <= tail_reg;
                    count_reg <= count_reg - 2'h1;
                end
                2'b11: begin
                    // count unchanged; one in, one out
                    if (count_reg == 2'h1) begin
                        head_reg <= i_in_data;
                    end else begin
                        head_reg <= tail_reg;
                        tail_reg <= i_in_data;
                    end
                end
                default: begin
                    count_reg <= count_reg;
                end
            endcase
        end
    end

endmodule // pair_buffer

`default_nettype wire

//--- tb/spi_buffer_status_flags_chk.sv
// concurrent checks on the ports of the serial buffer status block
`timescale 1ns/10ps
`default_nettype none
`include "spi_buffer_consts.vh"

module spi_buffer_status_flags_chk #(
    parameter DATA_W = 32,
    parameter DEPTH  = 8,
    parameter PTR_W  = 3
) (
    input wire              i_core_clk,  // core clock
    input wire              i_reset_n,   // async reset, active low
    input wire [7:0]        i_addr,      // byte address
    input wire [31:0]       i_wr_data,   // write data
    input wire              i_wr_en,     // write strobe
    input wire              i_rd_en,     // read strobe
    input wire [31:0]       o_rd_data,   // read data
    input wire              o_tx_valid,  // tx word offered
    input wire              i_tx_ready,  // shifter takes word
    input wire [DATA_W-1:0] o_tx_data,   // tx word
    input wire              i_rx_valid,  // rx word offered
    input wire              o_rx_ready,  // rx room
    input wire [DATA_W-1:0] i_rx_data    // rx word
);
    wire [DATA_W-1:0] wr_word = i_wr_data[DATA_W-1:0];
    wire              rx_take = i_rx_valid && o_rx_ready;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // ----------
    // sequences
    // ----------
    sequence s_stat_rd;
        i_rd_en && i_addr == `OFS_BUF_STATUS ##1 1'b1;
    endsequence
    // a quiet bus first, so nothing can still wait in the holding buffer
    sequence s_fresh_wr;
        !i_wr_en ##1 !i_wr_en ##1 (i_wr_en && i_addr == `OFS_DATA_WINDOW && !o_tx_valid);
    endsequence

    // ----------
    // properties
    // ----------
    chk_rd_quiet: assert property (!i_rd_en |=> o_rd_data == 32'h0)
        else $error("read data not zero outside a read answer");
    chk_bit2_zero: assert property (s_stat_rd |-> !o_rd_data[`BIT_STAT_UNUSED])
        else $error("status bit 2 read as one");
    chk_high_zero: assert property (s_stat_rd |-> o_rd_data[31:6] == 26'h0 && !o_rd_data[4])
        else $error("unused status bits read as one");
    chk_tx_excl: assert property (s_stat_rd |-> !(o_rd_data[`BIT_TX_FULL] && o_rd_data[`BIT_TX_EMPTY]))
        else $error("tx full and tx empty both set");
    chk_rx_excl: assert property (s_stat_rd |-> !(o_rd_data[`BIT_RX_FULL] && o_rd_data[`BIT_RX_EMPTY]))
        else $error("rx full and rx empty both set");
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("tx word changed before it was taken");
    chk_wr_pass: assert property (s_fresh_wr |-> ##2 o_tx_valid && o_tx_data == $past(wr_word, 2))
        else $error("written word did not reach the shifter side");
    chk_rx_stall: assert property ($fell(o_rx_ready) |-> $past(rx_take))
        else $error("rx ready dropped without an entering word");
endmodule // spi_buffer_status_flags_chk

bind spi_buffer_status_flags spi_buffer_status_flags_chk #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH),
    .PTR_W(PTR_W)
) spi_buffer_status_flags_chk_i (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready),
    .o_tx_data(o_tx_data),
    .i_rx_valid(i_rx_valid),
    .o_rx_ready(o_rx_ready),
    .i_rx_data(i_rx_data)
);
`default_nettype wire

//--- tb/shifter_model.sv
// behavioural model of the shift register side of the serial unit
`timescale 1ns/10ps
`default_nettype none

module shifter_model #(
    parameter DATA_W = 32
) (
    input  wire               i_core_clk, // core clock
    input  wire               i_reset_n,  // async reset, active low
    input  wire               i_tx_valid, // word offered by block
    output logic              o_tx_ready, // shifter takes word
    output logic              o_rx_valid, // received word offered
    input  wire               i_rx_ready, // block has room
    output logic [DATA_W-1:0] o_rx_data,  // received word
    input  wire               i_hold,     // stall the transmit side
    input  wire               i_slow      // take every other cycle
);
    logic [DATA_W-1:0] words[$];
    logic              tick;

    task automatic send(input [DATA_W-1:0] w);
        words.push_back(w);
    endtask

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_ready <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_data <= '0;
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
            o_tx_ready <= !i_hold && (!i_slow || tick);
            if (o_rx_valid && i_rx_ready)
                void'(words.pop_front());
            // idle data toggles so a stale word never looks valid
            if (words.size() > 0) begin
                o_rx_valid <= 1'b1;
                o_rx_data <= words[0];
            end else begin
                o_rx_valid <= 1'b0;
                o_rx_data <= ~o_rx_data;
            end
        end
    end
endmodule // shifter_model
`default_nettype wire

//--- tb/test_spi_buffer_status_flags.sv
// self-checking bench for the serial buffer status block
`timescale 1ns/10ps
`default_nettype none
`include "spi_buffer_consts.vh"

module test_spi_buffer_status_flags;
    localparam DW    = 32;
    localparam DEPTH = 8;
    logic          i_core_clk;
    logic          i_reset_n;
    logic [7:0]    i_addr;
    logic [31:0]   i_wr_data;
    logic          i_wr_en;
    logic          i_rd_en;
    wire  [31:0]   o_rd_data;
    wire           o_tx_valid, i_tx_ready, o_rx_ready, i_rx_valid;
    wire  [DW-1:0] o_tx_data, i_rx_data;
    logic          hold, slow, rd_d;
    logic [31:0]   seed;
    logic [31:0]   rd_exp[$];
    logic [DW-1:0] tx_exp[$], rx_exp[$];
    int            num_errors, tests_run;

    spi_buffer_status_flags #(.DATA_W(DW), .DEPTH(DEPTH), .PTR_W(3)) spi_buffer_status_flags_i (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_tx_valid(o_tx_valid),
        .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .i_rx_valid(i_rx_valid),
        .o_rx_ready(o_rx_ready), .i_rx_data(i_rx_data));

    shifter_model #(.DATA_W(DW)) shifter_model_i (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_tx_valid(o_tx_valid),
        .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .i_rx_ready(o_rx_ready),
        .o_rx_data(i_rx_data), .i_hold(hold), .i_slow(slow));

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    // ----------
    // helpers
    // ----------
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input [31:0] seen, input [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input [7:0] a, input [31:0] e);
        rd_exp.push_back(e);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_core_clk);
        i_rd_en <= 1'b0;
    endtask

    // read answers and shifter takes are matched against the oldest note
    always @(posedge i_core_clk) begin
        if (rd_d)
            chk(o_rd_data, rd_exp.pop_front());
        if (o_tx_valid && i_tx_ready)
            chk(o_tx_data, tx_exp.pop_front());
        rd_d <= i_rd_en;
    end

    // ----------
    // scenarios
    // ----------
    // thr is the write count at which the transmit side reports full
    task automatic tx_fill(input int thr);
        hold <= 1'b1;
        for (int k = 1; k <= thr + 1; k++) begin
            seed = lfsr(seed);
            if (k <= thr)
                tx_exp.push_back(seed);
            wr(`OFS_DATA_WINDOW, seed);
            idle(3);
            rd(`OFS_BUF_STATUS, 32'h20 | (k <= 2 ? 32'h8 : 32'h0) | (k >= thr ? 32'h2 : 32'h0));
        end
        hold <= 1'b0;
        slow <= 1'b1;
        for (int i = 0; i < 200 && tx_exp.size() > 0; i++)
            idle(1);
        chk(tx_exp.size(), 32'h0);
        rd(`OFS_BUF_STATUS, 32'h28);
    endtask

    // cap words fill storage, two the staging pair, one waits at the shifter
    task automatic rx_fill(input int cap);
        for (int k = 0; k < cap + 3; k++) begin
            seed = lfsr(seed);
            rx_exp.push_back(seed);
            shifter_model_i.send(seed);
        end
        idle(cap + 8);
        #10 chk(o_rx_ready, 32'h0);
        for (int r = cap + 3; r > 0; r--) begin
            rd(`OFS_BUF_STATUS, 32'h8 | (r >= cap ? 32'h1 : 32'h0));
            rd(`OFS_DATA_WINDOW, rx_exp.pop_front());
            idle(4);
        end
        rd(`OFS_BUF_STATUS, 32'h28);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        num_errors = 0;
        tests_run = 0;
        seed = 32'h00000051;
        i_reset_n = 1'b0;
        i_addr = 8'h00;
        i_wr_data = 32'h0;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        hold = 1'b0;
        slow = 1'b0;
        idle(5);
        i_reset_n <= 1'b1;
        rd(`OFS_BUF_STATUS, 32'h28);
        rd(`OFS_BUF_CONTROL, 32'h0);
        rd(8'h0C, 32'h0);
        wr(`OFS_BUF_STATUS, 32'hFFFFFFFF);
        rd(`OFS_BUF_STATUS, 32'h28);
        tx_fill(3);
        rx_fill(1);
        wr(`OFS_BUF_CONTROL, 32'h1);
        rd(`OFS_BUF_CONTROL, 32'h1);
        tx_fill(DEPTH + 1);
        rx_fill(DEPTH - 1);
        idle(4);
        chk(rd_exp.size(), 32'h0);
        end_of_test;
    end

    // run needs well under a thousand cycles
    initial begin
        #(100 * 20000);
        num_errors++;
        end_of_test;
    end
endmodule // test_spi_buffer_status_flags
`default_nettype wire
